//--- hdl/nfi_pkg.sv
// Package holding the fault inserter register map, encodings and field layouts.
package nfi_pkg;
   // Register offsets. Each physical channel owns a block of CH_STRIDE bytes.
   localparam logic [7:0] NFI_CH_STRIDE = 8'h10;
   localparam logic [3:0] NFI_REG_CTRL = 4'h0;
   localparam logic [3:0] NFI_REG_DELAY = 4'h4;
   localparam logic [3:0] NFI_REG_STAT = 4'h8;
   localparam logic [7:0] NFI_GLB_STAT = 8'h80;
   localparam logic [7:0] NFI_GLB_TIME = 8'h84;

   // Field layout of the channel control register.
   localparam int NFI_LCH_W = 3;
   localparam int NFI_CTRL_LCH_LSB = 0;
   localparam int NFI_CTRL_IN_LSB = 3;
   localparam int NFI_CTRL_OUT_LSB = 5;
   localparam int NFI_CTRL_EN_BIT = 7;
   localparam int NFI_CTRL_W = 8;

   // Experiment time and fault delay width in tolerant clock ticks.
   localparam int NFI_TIME_W = 24;

   // One tolerant clock tick, and the core clock period, in ns.
   localparam int NFI_TICK_NS = 4125;
   localparam int NFI_CLK_NS = 8;
   // Worst pass-through delay in ns and the register stages it allows.
   localparam int NFI_PASS_MAX_NS = 100;
   localparam int NFI_PASS_MAX_CYC = NFI_PASS_MAX_NS / NFI_CLK_NS;

   // Reset values.
   localparam logic [NFI_CTRL_W-1:0] NFI_CTRL_RST = 8'h00;
   localparam logic [NFI_TIME_W-1:0] NFI_DELAY_RST = 24'hFFFFFF;

   typedef enum logic [1:0] {
      NFI_PASS,
      NFI_LOW,
      NFI_HIGH
   } nfi_mode_t;

   // Settings of one physical channel.
   typedef struct packed {
      logic en;
      logic [1:0] out_mode;
      logic [1:0] in_mode;
      logic [NFI_LCH_W-1:0] lchan;
   } nfi_ctrl_t;

   // Force requests for one connector.
   typedef struct packed {
      logic lo;
      logic hi;
   } nfi_force_t;
endpackage

//--- hdl/nfi_fault_inserter.sv
// Network link fault inserter: APB register slave, delay timers and connector forcing.
`timescale 1ns/1ps

//Contract
// - With no fault applied, each connector's outputs repeat the opposite connector's inputs unaltered, one register stage late.
// - A passive failure drives every output line of the affected connector low while it lasts.
// - An active failure drives every output line of the affected connector high while it lasts.
// - Every channel is set up by the host through the register bus.
// - Each physical channel answers at its own distinct register block address.
// - There are enough channels to fail one to five links at once.
// - Each physical channel holds a programmable logical channel that picks the failed link.
// - Several physical channels may point at the same logical channel together.
// - The in and out connector modes of a channel are programmed separately.
// - The delay timer counts ticks of the shared tolerant clock timebase.
// - A fault begins within 100 microseconds of its scheduled delay after the run starts.
// - One timer tick is one tolerant clock period of 4.125 microseconds.
module nfi_fault_inserter
   import nfi_pkg::*;
#(
   parameter int NCH = 5,
   parameter int NLINK = 5,
   parameter int LINE_W = 2
) (
   // Clock and reset.
   input wire logic CORE_CLK,
   input wire logic RST_N,
   // APB slave.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Experiment timebase.
   input wire logic TOLERANT_CLOCK_TICK,
   input wire logic EXPERIMENT_RUN_STATE,
   // In connectors (toward the processor) and out connectors (away from it).
   input wire logic [NLINK-1:0][LINE_W-1:0] IN_RX,
   output logic [NLINK-1:0][LINE_W-1:0] IN_TX,
   input wire logic [NLINK-1:0][LINE_W-1:0] OUT_RX,
   output logic [NLINK-1:0][LINE_W-1:0] OUT_TX
);

   nfi_ctrl_t ctrl_q [NCH];
   logic [NFI_TIME_W-1:0] delay_q [NCH];
   logic [NCH-1:0] fired_q;
   logic run_q;
   logic [NFI_TIME_W-1:0] time_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   nfi_force_t in_f [NLINK];
   nfi_force_t out_f [NLINK];
   logic [NLINK-1:0][LINE_W-1:0] in_tx_q;
   logic [NLINK-1:0][LINE_W-1:0] out_tx_q;

   logic acc;
   logic [3:0] sel_ch;
   logic [3:0] sel_reg;
   logic ch_hit;
   logic [31:0] rd_d;
   logic rd_err_d;

   assign acc = PSEL && PENABLE && pready_q;
   assign sel_ch = PADDR[7:4];
   assign sel_reg = PADDR[3:0];
   assign ch_hit = ({28'h0000000, sel_ch} < 32'(NCH)) && (PADDR < NFI_GLB_STAT);

   // Experiment time: held at zero while stopped, counts ticks while running.
   // It saturates at all ones instead of wrapping, so a late fault cannot fire early.
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         run_q <= 1'b0;
      end else begin
         run_q <= EXPERIMENT_RUN_STATE;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         time_q <= '0;
      end else if (!run_q) begin
         time_q <= '0;
      end else if (TOLERANT_CLOCK_TICK && time_q != {NFI_TIME_W{1'b1}}) begin
         time_q <= time_q + 1'b1;
      end
   end

   // Per channel registers and onset detection.
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic wr_hit;
      assign wr_hit = acc && PWRITE && ch_hit && (sel_ch == 4'(c));

      always_ff @(posedge CORE_CLK) begin
         if (!RST_N) begin
            ctrl_q[c] <= NFI_CTRL_RST;
            delay_q[c] <= NFI_DELAY_RST;
         end else if (wr_hit && sel_reg == NFI_REG_CTRL) begin
            ctrl_q[c] <= PWDATA[NFI_CTRL_W-1:0];
         end else if (wr_hit && sel_reg == NFI_REG_DELAY) begin
            delay_q[c] <= PWDATA[NFI_TIME_W-1:0];
         end
      end

      // Onset is sticky for the rest of the run and cleared when the run stops.
      always_ff @(posedge CORE_CLK) begin
         if (!RST_N) begin
            fired_q[c] <= 1'b0;
         end else if (!run_q) begin
            fired_q[c] <= 1'b0;
         end else if (ctrl_q[c].en && time_q >= delay_q[c]) begin
            fired_q[c] <= 1'b1;
         end
      end
   end

   // Merge every fired channel onto its logical link. Active high wins over passive low.
   // Mode code 3 and logical links at or above NLINK match nothing, so those channels
   // leave traffic untouched.
   always_comb begin
      for (int l = 0; l < NLINK; l++) begin
         in_f[l] = '0;
         out_f[l] = '0;
         for (int c = 0; c < NCH; c++) begin
            if (fired_q[c] && 32'(ctrl_q[c].lchan) == l) begin
               in_f[l].lo = in_f[l].lo | (ctrl_q[c].in_mode == NFI_LOW);
               in_f[l].hi = in_f[l].hi | (ctrl_q[c].in_mode == NFI_HIGH);
               out_f[l].lo = out_f[l].lo | (ctrl_q[c].out_mode == NFI_LOW);
               out_f[l].hi = out_f[l].hi | (ctrl_q[c].out_mode == NFI_HIGH);
            end
         end
      end
   end

   // Connector outputs, one register stage, well inside the pass-through budget.
   for (genvar l = 0; l < NLINK; l++) begin : g_link
      always_ff @(posedge CORE_CLK) begin
         if (!RST_N) begin
            in_tx_q[l] <= '0;
         end else if (in_f[l].hi) begin
            in_tx_q[l] <= {LINE_W{1'b1}};
         end else if (in_f[l].lo) begin
            in_tx_q[l] <= '0;
         end else begin
            in_tx_q[l] <= OUT_RX[l];
         end
      end

      always_ff @(posedge CORE_CLK) begin
         if (!RST_N) begin
            out_tx_q[l] <= '0;
         end else if (out_f[l].hi) begin
            out_tx_q[l] <= {LINE_W{1'b1}};
         end else if (out_f[l].lo) begin
            out_tx_q[l] <= '0;
         end else begin
            out_tx_q[l] <= IN_RX[l];
         end
      end
   end

   // Read mux and error decode. Writes to read-only words are dropped without an error,
   // while unaligned or unmapped words answer with PSLVERR.
   always_comb begin
      rd_d = '0;
      rd_err_d = 1'b0;
      if (PADDR[1:0] != 2'h0) begin
         rd_err_d = 1'b1;
      end else if (PADDR == NFI_GLB_STAT) begin
         rd_d = {24'h000000, 7'h00, run_q};
      end else if (PADDR == NFI_GLB_TIME) begin
         rd_d = {8'h00, time_q};
      end else if (!ch_hit) begin
         rd_err_d = 1'b1;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (sel_ch == 4'(c)) begin
               if (sel_reg == NFI_REG_CTRL) begin
                  rd_d = {24'h000000, ctrl_q[c]};
               end else if (sel_reg == NFI_REG_DELAY) begin
                  rd_d = {8'h00, delay_q[c]};
               end else if (sel_reg == NFI_REG_STAT) begin
                  rd_d = {31'h00000000, fired_q[c]};
               end else begin
                  rd_err_d = 1'b1;
               end
            end
         end
      end
   end

   // One wait state: PREADY rises in the second access cycle with data and error.
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= PSEL && PENABLE && !pready_q;
         pslverr_q <= PSEL && PENABLE && !pready_q && rd_err_d;
         prdata_q <= (PSEL && PENABLE && !pready_q && !PWRITE) ? rd_d : 32'h00000000;
      end
   end

   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign PRDATA = prdata_q;
   assign IN_TX = in_tx_q;
   assign OUT_TX = out_tx_q;

   // Checks. The run state and pass-through properties, which look one cycle back, also require RST_N in the antecedent,
   // so the edge that releases reset never compares against reset values.
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   // Register bus handshake and answer lines.
   a_apb_ready_wait: assert property (
      PSEL && PENABLE && !pready_q
      |=> pready_q)
      else $error("access phase not answered after one wait state");
   a_apb_ready_once: assert property (
      pready_q
      |=> !pready_q)
      else $error("ready held for more than one cycle");
   a_apb_err_ready: assert property (
      pslverr_q
      |-> pready_q)
      else $error("error flag raised without ready");
   a_apb_data_idle: assert property (
      !pready_q
      |-> prdata_q == 32'h00000000)
      else $error("read data not zero outside the answer cycle");
   a_apb_err_align: assert property (
      PSEL && PENABLE && !pready_q && PADDR[1:0] != 2'h0
      |=> pslverr_q)
      else $error("unaligned access not refused");
   a_apb_err_unmapped: assert property (
      PSEL && PENABLE && !pready_q && PADDR[1:0] == 2'h0 && !ch_hit
      && PADDR != NFI_GLB_STAT && PADDR != NFI_GLB_TIME
      |=> pslverr_q)
      else $error("unmapped access not refused");
   a_apb_good_addr: assert property (
      PSEL && PENABLE && !pready_q && PADDR[1:0] == 2'h0 && ch_hit && sel_reg != 4'hC
      |=> !pslverr_q)
      else $error("mapped channel word refused");

   // Run state and experiment time.
   a_run_follow: assert property (
      RST_N
      |=> run_q == $past(EXPERIMENT_RUN_STATE))
      else $error("run state not registered");
   a_time_stop_zero: assert property (
      !run_q
      |=> time_q == '0)
      else $error("experiment time not held at zero while stopped");
   a_time_tick_step: assert property (
      run_q && EXPERIMENT_RUN_STATE && TOLERANT_CLOCK_TICK
      && time_q != {NFI_TIME_W{1'b1}}
      |=> time_q == $past(time_q) + 1'b1)
      else $error("tick did not advance experiment time");
   a_time_no_tick: assert property (
      run_q && !TOLERANT_CLOCK_TICK
      |=> time_q == $past(time_q))
      else $error("experiment time moved without a tick");
   a_time_saturate: assert property (
      run_q && time_q == {NFI_TIME_W{1'b1}}
      |=> time_q == {NFI_TIME_W{1'b1}})
      else $error("experiment time wrapped");
   a_time_run_start: assert property (
      $rose(run_q)
      |-> time_q == '0)
      else $error("experiment time not zero at run start");

   // Per channel settings and onset.
   for (genvar c = 0; c < NCH; c++) begin : g_chk
      a_onset_on_time: assert property (
         run_q && EXPERIMENT_RUN_STATE && ctrl_q[c].en
         && time_q == delay_q[c]
         |=> fired_q[c])
         else $error("fault did not start when delay was reached");
      a_onset_not_early: assert property (
         $rose(fired_q[c])
         |-> $past(time_q) >= $past(delay_q[c]))
         else $error("fault started before its delay");
      a_fault_sticky: assert property (
         fired_q[c] && run_q
         |=> fired_q[c])
         else $error("fault ended during the run");
      a_fault_stop_clear: assert property (
         !run_q
         |=> !fired_q[c])
         else $error("fault stayed while stopped");
      a_disabled_silent: assert property (
         !ctrl_q[c].en && !fired_q[c]
         |=> !fired_q[c])
         else $error("disabled channel started a fault");
      a_ctrl_write: assert property (
         acc && PWRITE && ch_hit && sel_ch == 4'(c)
         && sel_reg == NFI_REG_CTRL
         |=> ctrl_q[c] == $past(PWDATA[NFI_CTRL_W-1:0]))
         else $error("control write not stored");
      a_delay_write: assert property (
         acc && PWRITE && ch_hit && sel_ch == 4'(c)
         && sel_reg == NFI_REG_DELAY
         |=> delay_q[c] == $past(PWDATA[NFI_TIME_W-1:0]))
         else $error("delay write not stored");
      a_ctrl_hold: assert property (
         !(acc && PWRITE)
         |=> $stable(ctrl_q[c]))
         else $error("control changed without a write");
      a_delay_hold: assert property (
         !(acc && PWRITE)
         |=> $stable(delay_q[c]))
         else $error("delay changed without a write");
   end

   // Connector outputs: pass-through, passive low and active high on both sides.
   for (genvar l = 0; l < NLINK; l++) begin : g_lchk
      a_pass_unaltered: assert property (
         RST_N && !in_f[l].lo && !in_f[l].hi
         |=> IN_TX[l] == $past(OUT_RX[l]))
         else $error("in connector altered without a fault");
      a_out_pass: assert property (
         RST_N && !out_f[l].lo && !out_f[l].hi
         |=> OUT_TX[l] == $past(IN_RX[l]))
         else $error("out connector altered without a fault");
      a_passive_low: assert property (
         out_f[l].lo && !out_f[l].hi
         |=> OUT_TX[l] == '0)
         else $error("passive fault did not hold lines low");
      a_in_passive_low: assert property (
         in_f[l].lo && !in_f[l].hi
         |=> IN_TX[l] == '0)
         else $error("passive fault did not hold in lines low");
      a_active_high: assert property (
         in_f[l].hi
         |=> IN_TX[l] == {LINE_W{1'b1}})
         else $error("active fault did not hold lines high");
      a_out_active_high: assert property (
         out_f[l].hi
         |=> OUT_TX[l] == {LINE_W{1'b1}})
         else $error("active fault did not hold out lines high");
   end

   // Main scenarios.
   c_run_start: cover property (!run_q ##1 run_q ##[1:600] TOLERANT_CLOCK_TICK);
   c_fault_fires: cover property ($rose(fired_q[0]));
   c_shared_link: cover property (fired_q[0] && fired_q[1] && ctrl_q[0].lchan == ctrl_q[1].lchan);
   c_bad_address: cover property (pready_q && pslverr_q);
   c_active_wins: cover property (out_f[1].lo && out_f[1].hi);
endmodule

//--- sim/nfi_link_model.sv
// Far side model: tolerant clock timebase, run state and link traffic.
`timescale 1ns/1ps
module nfi_link_model #(
   parameter int TICK_CYC = 516
) (
   // Bench side.
   input wire logic clk,
   input wire logic run_go,
   // Device side.
   output logic tick,
   output logic run,
   output logic [4:0][1:0] in_rx,
   output logic [4:0][1:0] out_rx
);
   int cnt = 0;
   logic [9:0] pat = 10'h000;
   // Ticks run free at about 4.125 us; traffic changes every cycle so stale lines show.
   always @(posedge clk) begin
      cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
      tick <= (cnt == TICK_CYC - 1);
      run <= run_go;
      pat <= pat + 10'h0D7;
      in_rx <= pat;
      out_rx <= ~pat ^ 10'h155;
   end
endmodule

//--- sim/nfi_fault_inserter_tb.sv
// Self-checking bench for the network link fault inserter.
`timescale 1ns/1ps
module nfi_fault_inserter_tb;
   import nfi_pkg::*;
   localparam int DLY_US = 124;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rdv;
   logic pready, pslverr, errv, tick, run;
   logic run_go = 1'b0;
   logic [4:0][1:0] in_rx, in_tx, out_rx, out_tx;
   logic [31:0] cv [5];
   logic [23:0] dly;
   int fails = 0;
   int total_checks = 0;
   int cyc = 0;
   int t0, n, e;

   always #4 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   nfi_fault_inserter i_dut (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .TOLERANT_CLOCK_TICK(tick), .EXPERIMENT_RUN_STATE(run),
      .IN_RX(in_rx), .IN_TX(in_tx), .OUT_RX(out_rx), .OUT_TX(out_tx));
   nfi_link_model i_far (.clk(clk), .run_go(run_go), .tick(tick), .run(run),
      .in_rx(in_rx), .out_rx(out_rx));

   task automatic results;
      if (fails == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, x, s);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic er);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for an answer that never comes.
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
      apb(1'b1, a, d, rdv, errv);
      chk("pslverr", 32'(errv), 32'(x));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic x);
      apb(1'b0, a, 32'h00000000, rdv, errv);
      chk("prdata", rdv, d);
      chk("pslverr", 32'(errv), 32'(x));
   endtask

   function automatic logic [31:0] ctl(input logic en, input logic [1:0] om,
                                       input logic [1:0] im, input logic [2:0] l);
      return {24'h000000, en, om, im, l};
   endfunction

   function automatic logic [1:0] lvl(input logic [1:0] m, input logic [1:0] p);
      return (m == NFI_LOW) ? 2'h0 : (m == NFI_HIGH) ? 2'h3 : p;
   endfunction

   // Each link line is checked against the level its connector mode demands.
   task automatic lnk_chk(input int cnt, input logic [9:0] im, input logic [9:0] om);
      logic [4:0][1:0] pi, po;
      @(negedge clk);
      pi = in_rx;
      po = out_rx;
      repeat (cnt) begin
         @(negedge clk);
         for (int l = 0; l < 5; l++) begin
            chk("in_tx", 32'(in_tx[l]), 32'(lvl(im[2*l+:2], po[l])));
            chk("out_tx", 32'(out_tx[l]), 32'(lvl(om[2*l+:2], pi[l])));
         end
         pi = in_rx;
         po = out_rx;
      end
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      results();
   end

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(8'h00, 32'(NFI_CTRL_RST), 1'b0);
      rd(8'h14, 32'(NFI_DELAY_RST), 1'b0);
      rd(8'h0C, 32'h00000000, 1'b1);
      wr(8'h0C, 32'h000000FF, 1'b1);
      rd(8'h01, 32'h00000000, 1'b1);
      rd(8'h50, 32'h00000000, 1'b1);
      rd(NFI_GLB_STAT, 32'h00000000, 1'b0);
      rd(NFI_GLB_TIME, 32'h00000000, 1'b0);
      lnk_chk(16, 10'h000, 10'h000);
      dly = 24'((DLY_US * 1000) / NFI_TICK_NS);
      cv = '{ctl(1'b1, NFI_HIGH, NFI_LOW, 3'h1), ctl(1'b1, NFI_LOW, NFI_LOW, 3'h1),
         ctl(1'b1, NFI_LOW, NFI_HIGH, 3'h2), ctl(1'b0, NFI_HIGH, NFI_HIGH, 3'h0),
         ctl(1'b1, NFI_LOW, NFI_LOW, 3'h5)};
      for (int c = 0; c < 5; c++) begin
         wr(8'(c * 16), cv[c], 1'b0);
         wr(8'(c * 16 + 4), 32'(dly), 1'b0);
      end
      for (int c = 0; c < 5; c++) rd(8'(c * 16), cv[c], 1'b0);
      wr(8'h08, 32'h00000001, 1'b0);
      rd(8'h08, 32'h00000000, 1'b0);
      lnk_chk(8, 10'h000, 10'h000);
      @(posedge clk);
      run_go <= 1'b1;
      t0 = cyc;
      n = 0;
      do begin
         apb(1'b0, 8'h08, 32'h00000000, rdv, errv);
         n++;
      end while (rdv[0] !== 1'b1 && n < 10000);
      e = (cyc - t0) * NFI_CLK_NS - DLY_US * 1000;
      chk("onset", 32'(e <= 100000 && e >= -100000), 32'h00000001);
      apb(1'b0, NFI_GLB_TIME, 32'h00000000, rdv, errv);
      chk("time", 32'(rdv[23:0] >= dly && rdv[23:0] <= dly + 24'h000001), 32'h00000001);
      repeat (2) @(posedge clk);
      lnk_chk(12, 10'h024, 10'h018);
      rd(8'h28, 32'h00000001, 1'b0);
      rd(8'h38, 32'h00000000, 1'b0);
      rd(NFI_GLB_STAT, 32'h00000001, 1'b0);
      @(posedge clk);
      run_go <= 1'b0;
      repeat (4) @(posedge clk);
      lnk_chk(8, 10'h000, 10'h000);
      rd(NFI_GLB_TIME, 32'h00000000, 1'b0);
      rd(8'h08, 32'h00000000, 1'b0);
      results();
   end
endmodule
